// ---- hw/hdlc_status_defines.svh ----
// Offsets, field positions, reset values and timing counts of the HDLC status block.
`ifndef HDLC_STATUS_DEFINES_SVH
`define HDLC_STATUS_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define OFS_COMMAND 8'h00
`define OFS_CONFIG 8'h04
`define OFS_RAH_ONE 8'h08
`define OFS_RAH_TWO 8'h0c
`define OFS_RAL_ONE 8'h10
`define OFS_RAL_TWO 8'h14
`define OFS_RX_QUEUE 8'h18
`define OFS_SIG_STATUS 8'h64
`define OFS_RX_STATUS 8'h68
`define OFS_RBC_LOW 8'h6c
`define OFS_RBC_HIGH 8'h70

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CMD_XRESET 0
`define CMD_REPEAT 1
`define CFG_MODE_LSB 0
`define CFG_MODE_MSB 2
`define CFG_RX_CHECK 3
`define CFG_SS7 4
`define SIS_TX_OVF 7
`define SIS_TX_WOK 6
`define SIS_REPEAT 5
`define SIS_CMD_BUSY 2
`define SIS_BOM 0

// ----------------------------------------------------------------------------
// Codes, limits and reset values
// ----------------------------------------------------------------------------
`define MODE_ADDR16 3'b011
`define MODE_ADDR8 3'b010
`define BCAST_A 8'hfe
`define BCAST_B 8'hfc
`define TX_HALF_BYTES 7'd32
`define SS7_MAX_OCTETS 12'd279
`define LEN_MAX 12'd4095
`define REG_RESET 8'h00
`define SU_FISU_LEN 12'd3
`define SU_LSSU_LEN 12'd5

// ----------------------------------------------------------------------------
// Command-executing time: 2.5 periods of a 1.544 Mbit/s data rate, in ns
// ----------------------------------------------------------------------------
`define CEC_MAX_NS 1619
`define CLK_PERIOD_NS 20
`define CEC_CYCLES (`CEC_MAX_NS / `CLK_PERIOD_NS)

`endif

// ---- hw/hdlc_status_pkg.sv ----
// Types shared by the HDLC status block.
package hdlc_status_pkg;
   typedef enum logic [0:0] {
      CMD_IDLE = 1'b0,
      CMD_BUSY = 1'b1
   } cmd_state_t;
   typedef logic [7:0] byte_t;
endpackage

// ---- hw/hdlc_status.sv ----
// HDLC channel status reporting with an AHB-Lite register slave.
//
// What this block does
// - Set transmit overflow flag when more than 32 bytes written to transmit queue.
// - Transmitter reset command clears the transmit overflow flag.
// - Moving the accessible queue half onward also clears the overflow flag.
// - Write-ok bit is high whenever the host may write more transmit data.
// - Status bit mirrors the transmission-repeat bit of the command register.
// - Busy flag 0 when command register writable, 1 while a command runs.
// - Busy flag lasts at most 2.5 data-rate periods after each command.
// - Mode bit 0 HDLC, 1 bit-oriented message; only in ESF with auto switching.
// - Status byte of each kept frame is appended to the receive queue at frame end if the queue has room.
// - Frame whose length is not whole bytes is marked invalid.
// - 16-bit address mode: 4 bytes invalid, or 3-4 bytes with check on.
// - 8-bit address mode: 3 bytes invalid, or 2-3 bytes with check on.
// - Frames shorter than those limits are dropped without any report.
// - Overflow bit set when receive data was lost during the frame.
// - Check bit 0 on failed frame check, 1 on an error-free frame.
// - SS7 mode sets the aborted bit when a frame exceeds 279 octets.
// - High address byte compared with two registers and broadcast FE, FC.
// - High match code 00 second, 01 broadcast, 1x first register with C/R.
// - In SS7 the high match code gives the signal unit type.
// - Format bit 0 for bit-oriented message, 1 for HDLC frame.
// - Low address bit 1 on first-register match, 0 on second.
// - Byte count registers give frame length; low five bits give queue fill.
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`include "hdlc_status_defines.svh"

module hdlc_status
   import hdlc_status_pkg::*;
#(
   parameter int QDEPTH = 32,
   parameter int QAW = 5
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Transmit side events
   input wire logic tx_host_write,
   input wire logic tx_half_moved,
   // Framer mode inputs
   input wire logic esf_format,
   input wire logic auto_switch_en,
   input wire logic bom_active,
   // Receive side byte stream
   input wire logic rx_byte_valid,
   input wire logic [7:0] rx_byte,
   input wire logic rx_frame_end,
   input wire logic rx_bit_misalign,
   input wire logic rx_check_ok,
   input wire logic rx_is_bom,
   // Frame end notice
   output logic rx_message_end
);

   // -------------------------------------------------------------------------
   // Register state
   // -------------------------------------------------------------------------
   logic transmission_repeat;
   logic [7:0] cfg;
   byte_t high_address_reg_one, high_address_reg_two;
   byte_t low_address_reg_one, low_address_reg_two;
   logic tx_overflow_flag;
   logic [6:0] tx_count;
   cmd_state_t cmd_state;
   logic [7:0] cec_cnt;
   byte_t receive_frame_status;
   logic [11:0] last_len;

   // Bus data-phase capture.
   logic ph_wr;
   logic [7:0] ph_addr;
   logic ap_valid;
   logic cmd_write;
   logic [2:0] operating_mode_select;
   logic receive_check_on, ss7_mode;

   assign ap_valid = hsel && htrans[1] && hready;
   assign operating_mode_select = cfg[`CFG_MODE_MSB:`CFG_MODE_LSB];
   assign receive_check_on = cfg[`CFG_RX_CHECK];
   assign ss7_mode = cfg[`CFG_SS7];
   // Commands are ignored while one is still executing.
   assign cmd_write = ph_wr && (ph_addr == `OFS_COMMAND) && (cmd_state == CMD_IDLE);

   // -------------------------------------------------------------------------
   // AHB-Lite handshake
   // -------------------------------------------------------------------------
   // Zero wait states; only whole words are meaningful, narrower writes land too.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_wr <= 1'b0;
         ph_addr <= 8'h00;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         ph_wr <= ap_valid && hwrite;
         if (ap_valid) begin
            ph_addr <= {haddr[7:2], 2'b00};
         end
      end
   end

   // Writable configuration; status and count offsets are not decoded here.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg <= `REG_RESET;
         high_address_reg_one <= `REG_RESET;
         high_address_reg_two <= `REG_RESET;
         low_address_reg_one <= `REG_RESET;
         low_address_reg_two <= `REG_RESET;
      end else if (ph_wr) begin
         case (ph_addr)
            `OFS_CONFIG: cfg <= hwdata[7:0];
            `OFS_RAH_ONE: high_address_reg_one <= hwdata[7:0];
            `OFS_RAH_TWO: high_address_reg_two <= hwdata[7:0];
            `OFS_RAL_ONE: low_address_reg_one <= hwdata[7:0];
            `OFS_RAL_TWO: low_address_reg_two <= hwdata[7:0];
            default: cfg <= cfg;
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // Command register and executing flag
   // -------------------------------------------------------------------------
   // The busy window is a fixed count, rounded down so it never overruns.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmd_state <= CMD_IDLE;
         cec_cnt <= 8'h00;
         transmission_repeat <= 1'b0;
      end else begin
         case (cmd_state)
            CMD_IDLE: begin
               if (cmd_write) begin
                  cmd_state <= CMD_BUSY;
                  cec_cnt <= 8'((`CEC_CYCLES) - 1);
                  transmission_repeat <= hwdata[`CMD_REPEAT];
               end
            end
            CMD_BUSY: begin
               if (cec_cnt == 8'h00) begin
                  cmd_state <= CMD_IDLE;
               end else begin
                  cec_cnt <= cec_cnt - 8'h01;
               end
            end
            default: cmd_state <= CMD_IDLE;
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // Transmit queue overflow tracking
   // -------------------------------------------------------------------------
   // Only the host-facing half is counted; the move empties it at once.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_count <= 7'd0;
         tx_overflow_flag <= 1'b0;
      end else if (cmd_write && hwdata[`CMD_XRESET]) begin
         tx_count <= 7'd0;
         tx_overflow_flag <= 1'b0;
      end else if (tx_half_moved) begin
         tx_count <= 7'd0;
         tx_overflow_flag <= 1'b0;
      end else if (tx_host_write) begin
         if (tx_count != 7'h7f) begin
            tx_count <= tx_count + 7'd1;
         end
         if (tx_count >= `TX_HALF_BYTES) begin
            tx_overflow_flag <= 1'b1;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Receive queue
   // -------------------------------------------------------------------------
   // The array holds data bytes and the status byte closing each kept frame that finds room.
   byte_t qmem [QDEPTH];
   logic [QAW-1:0] wr_ptr, rd_ptr, start_ptr;
   logic [QAW:0] q_count, frame_in_q;
   logic q_full, q_empty, q_pop, data_push, stat_push, discard;
   byte_t status_byte;

   assign q_full = (q_count == (QAW+1)'(QDEPTH));
   assign q_empty = (q_count == '0);
   assign q_pop = ap_valid && !hwrite && ({haddr[7:2], 2'b00} == `OFS_RX_QUEUE) && !q_empty;
   assign data_push = rx_byte_valid && !q_full;
   assign stat_push = rx_frame_end && !discard && !q_full;

   always_ff @(posedge hclk) begin
      if (data_push) begin
         qmem[wr_ptr] <= rx_byte;
      end else if (stat_push) begin
         qmem[wr_ptr] <= status_byte;
      end
   end

   // Dropped frames rewind the write side to where they began.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         start_ptr <= '0;
         q_count <= '0;
         frame_in_q <= '0;
      end else begin
         if (q_pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (rx_frame_end && discard) begin
            wr_ptr <= start_ptr;
            q_count <= q_count - frame_in_q - (QAW+1)'(q_pop);
            frame_in_q <= '0;
         end else begin
            if (data_push || stat_push) begin
               wr_ptr <= wr_ptr + 1'b1;
            end
            q_count <= q_count + (QAW+1)'(data_push || stat_push) - (QAW+1)'(q_pop);
            if (rx_frame_end) begin
               start_ptr <= wr_ptr + QAW'(stat_push);
               frame_in_q <= '0;
            end else if (data_push) begin
               frame_in_q <= frame_in_q + 1'b1;
            end
         end
      end
   end

   // -------------------------------------------------------------------------
   // Frame length, address capture and overflow per frame
   // -------------------------------------------------------------------------
   logic [11:0] frame_len;
   byte_t first_byte, second_byte;
   logic frame_ovf;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         frame_len <= 12'd0;
         first_byte <= 8'h00;
         second_byte <= 8'h00;
         frame_ovf <= 1'b0;
      end else if (rx_frame_end) begin
         frame_len <= 12'd0;
         frame_ovf <= 1'b0;
      end else if (rx_byte_valid) begin
         if (frame_len != `LEN_MAX) begin
            frame_len <= frame_len + 12'd1;
         end
         if (frame_len == 12'd0) begin
            first_byte <= rx_byte;
         end
         if (frame_len == 12'd1) begin
            second_byte <= rx_byte;
         end
         if (q_full) begin
            frame_ovf <= 1'b1;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Status byte evaluation at frame end
   // -------------------------------------------------------------------------
   logic [11:0] lim_lo, lim_hi;
   logic too_short, frame_valid, rx_message_aborted, low_address_match;
   logic [1:0] high_address_match;
   logic two_byte_addr;
   byte_t low_byte;

   assign two_byte_addr = (operating_mode_select == `MODE_ADDR16) || ss7_mode;
   assign low_byte = two_byte_addr ? second_byte : first_byte;

   // Short-frame limits per address mode and receive check setting.
   always_comb begin
      lim_lo = 12'd0;
      lim_hi = 12'd0;
      if (operating_mode_select == `MODE_ADDR16) begin
         lim_lo = receive_check_on ? 12'd3 : 12'd4;
         lim_hi = 12'd4;
      end else if (operating_mode_select == `MODE_ADDR8) begin
         lim_lo = receive_check_on ? 12'd2 : 12'd3;
         lim_hi = 12'd3;
      end
   end

   assign discard = (frame_len < lim_lo);
   assign too_short = (frame_len <= lim_hi) && (lim_hi != 12'd0);
   assign frame_valid = !rx_bit_misalign && !too_short;
   assign rx_message_aborted = ss7_mode && (frame_len > `SS7_MAX_OCTETS);
   assign low_address_match = (low_byte == low_address_reg_one);

   // High byte match; the C/R bit is excluded from the first-register compare.
   always_comb begin
      high_address_match = 2'b00;
      if (ss7_mode) begin
         if (frame_len == `SU_FISU_LEN) begin
            high_address_match = 2'b01;
         end else if (frame_len > `SU_FISU_LEN && frame_len <= `SU_LSSU_LEN) begin
            high_address_match = 2'b10;
         end else if (frame_len > `SU_LSSU_LEN) begin
            high_address_match = 2'b11;
         end
      end else if ({first_byte[7:2], first_byte[0]} ==
                   {high_address_reg_one[7:2], high_address_reg_one[0]}) begin
         high_address_match = {1'b1, first_byte[1]};
      end else if (first_byte == high_address_reg_two) begin
         high_address_match = 2'b00;
      end else if (first_byte == `BCAST_A || first_byte == `BCAST_B) begin
         high_address_match = 2'b01;
      end
   end

   // Layout: valid, overflow, check, aborted, high match, format, low match.
   assign status_byte = {frame_valid, frame_ovf, rx_check_ok, rx_message_aborted,
                         high_address_match, !rx_is_bom, low_address_match};

   // Last reported frame: status copy and length for the count registers.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         receive_frame_status <= `REG_RESET;
         last_len <= 12'd0;
         rx_message_end <= 1'b0;
      end else begin
         rx_message_end <= rx_frame_end && !discard;
         if (rx_frame_end && !discard) begin
            receive_frame_status <= status_byte;
            last_len <= frame_len;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Read data
   // -------------------------------------------------------------------------
   byte_t hdlc_signaling_status, receive_byte_count_low, rx_count_high_reg;
   logic [31:0] next_hrdata;
   logic [QAW:0] fill;

   // Fill level read back excludes nothing: status bytes count as stored bytes.
   assign fill = q_count;

   always_comb begin
      hdlc_signaling_status = 8'h00;
      hdlc_signaling_status[`SIS_TX_OVF] = tx_overflow_flag;
      hdlc_signaling_status[`SIS_TX_WOK] = !tx_overflow_flag &&
                                           (tx_count < `TX_HALF_BYTES);
      hdlc_signaling_status[`SIS_REPEAT] = transmission_repeat;
      hdlc_signaling_status[`SIS_CMD_BUSY] = (cmd_state == CMD_BUSY);
      hdlc_signaling_status[`SIS_BOM] = esf_format && auto_switch_en && bom_active;
   end

   assign receive_byte_count_low = {last_len[7:5], fill[4:0]};
   assign rx_count_high_reg = {4'h0, last_len[11:8]};

   // Unmapped offsets read as zero; the response is always OKAY.
   always_comb begin
      next_hrdata = 32'h0;
      case ({haddr[7:2], 2'b00})
         `OFS_COMMAND: next_hrdata = {30'h0, transmission_repeat, 1'b0};
         `OFS_CONFIG: next_hrdata = {24'h0, cfg};
         `OFS_RAH_ONE: next_hrdata = {24'h0, high_address_reg_one};
         `OFS_RAH_TWO: next_hrdata = {24'h0, high_address_reg_two};
         `OFS_RAL_ONE: next_hrdata = {24'h0, low_address_reg_one};
         `OFS_RAL_TWO: next_hrdata = {24'h0, low_address_reg_two};
         `OFS_RX_QUEUE: next_hrdata = {24'h0, q_empty ? 8'h00 : qmem[rd_ptr]};
         `OFS_SIG_STATUS: next_hrdata = {24'h0, hdlc_signaling_status};
         `OFS_RX_STATUS: next_hrdata = {24'h0, receive_frame_status};
         `OFS_RBC_LOW: next_hrdata = {24'h0, receive_byte_count_low};
         `OFS_RBC_HIGH: next_hrdata = {24'h0, rx_count_high_reg};
         default: next_hrdata = 32'h0;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0;
      end else if (ap_valid && !hwrite) begin
         hrdata <= next_hrdata;
      end
   end

endmodule

// ---- verif/hdlc_status_properties.sv ----
// Port-level assertions for the HDLC status block.
`timescale 1ns/1ps
module hdlc_status_properties (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Register bus
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   // Mode and receive events
   input wire logic esf_format,
   input wire logic auto_switch_en,
   input wire logic bom_active,
   input wire logic rx_frame_end,
   input wire logic rx_message_end
);
   // ------------------------------------------------------------
   // Helper logic
   // ------------------------------------------------------------
   logic take;
   logic cmd_q, stat_q, cnth_q, rep_q, mode_q;
   logic [7:0] since_cmd;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // A transfer is taken on the same qualifiers that the slave uses.
   assign take = hsel && htrans[1] && hready;
   // Remember which register the current data phase belongs to, and last cycle's bom_active.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmd_q <= 1'b0;
         stat_q <= 1'b0;
         cnth_q <= 1'b0;
         mode_q <= 1'b0;
      end else begin
         cmd_q <= take && hwrite && haddr[7:2] == 6'h00;
         stat_q <= take && !hwrite && haddr[7:2] == 6'h19;
         cnth_q <= take && !hwrite && haddr[7:2] == 6'h1c;
         mode_q <= bom_active;
      end
   end
   // Age of the last accepted command; a write in the busy window is dropped, so it
   // must not restart the count.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         since_cmd <= 8'hff;
         rep_q <= 1'b0;
      end else if (cmd_q && since_cmd >= 8'd80) begin
         since_cmd <= 8'h00;
         rep_q <= hwdata[1];
      end else if (since_cmd != 8'hff) begin
         since_cmd <= since_cmd + 8'h01;
      end
   end
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("bus answer is not ready and okay");
   busy_window_a: assert property (stat_q && since_cmd inside {[8'd2:8'd70]} |-> hrdata[2])
      else $error("command flag low while a command runs");
   busy_end_a: assert property (stat_q && since_cmd >= 8'd100 |-> !hrdata[2])
      else $error("command flag held too long");
   repeat_mirror_a: assert property (stat_q |-> hrdata[5] == $past(rep_q))
      else $error("repeat status differs from command");
   write_gate_a: assert property (stat_q && hrdata[7] |-> !hrdata[6])
      else $error("write allowed during overflow");
   mode_bit_a: assert property (stat_q && $past(esf_format) && $past(auto_switch_en)
      && $past(bom_active) == $past(mode_q) |-> hrdata[0] == $past(bom_active))
      else $error("mode bit differs from channel mode");
   msg_cause_a: assert property (rx_message_end |-> $past(rx_frame_end))
      else $error("frame end notice without frame end");
   msg_pulse_a: assert property (rx_message_end |=> !rx_message_end)
      else $error("frame end notice longer than one cycle");
   count_high_a: assert property (cnth_q |-> hrdata[31:4] == 28'h0)
      else $error("count high has bits above eleven");
endmodule

bind hdlc_status hdlc_status_properties hdlc_status_properties_inst (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .hrdata(hrdata), .esf_format(esf_format), .auto_switch_en(auto_switch_en),
   .bom_active(bom_active), .rx_frame_end(rx_frame_end), .rx_message_end(rx_message_end)
);

// ---- verif/testbench.sv ----
// Self-checking testbench for the HDLC status block.
`timescale 1ns/1ps
module testbench
   import hdlc_status_pkg::*;
;
   // ------------------------------------------------------------
   // Signals and tasks
   // ------------------------------------------------------------
   localparam logic [7:0] A_CMD = 8'h00, A_CFG = 8'h04, A_RXQ = 8'h18, A_STAT = 8'h64;
   localparam logic [7:0] A_FST = 8'h68, A_CNTL = 8'h6c, A_CNTH = 8'h70;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, rx_message_end;
   logic [7:0] haddr;
   byte_t rx_byte;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, rd;
   logic tx_host_write, tx_half_moved, esf_format, auto_switch_en, bom_active;
   logic rx_byte_valid, rx_frame_end, rx_bit_misalign, rx_check_ok, rx_is_bom;
   int err_count;
   int comparisons;
   assign hready = hreadyout;
   hdlc_status hdlc_status_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tx_host_write(tx_host_write),
      .tx_half_moved(tx_half_moved), .esf_format(esf_format), .auto_switch_en(auto_switch_en),
      .bom_active(bom_active), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
      .rx_frame_end(rx_frame_end), .rx_bit_misalign(rx_bit_misalign),
      .rx_check_ok(rx_check_ok), .rx_is_bom(rx_is_bom), .rx_message_end(rx_message_end));
   // The clock toggles every half period of 20 ns.
   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end
   task automatic stop_test;
      if (err_count == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // One single transfer; read data is taken at the edge that ends the data phase.
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask
   task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e,
         input logic [31:0] m = 32'hffffffff);
      bus(1'b0, a, 32'h0);
      chk(n, rd & m, e);
   endtask
   task automatic tx_push(input int k);
      repeat (k) begin
         tx_host_write <= 1'b1;
         @(posedge hclk);
      end
      tx_host_write <= 1'b0;
   endtask
   // Flags are {misaligned, check good, bit-oriented}; they stand as levels at frame end.
   task automatic frame(input int n, input byte_t b0, input byte_t b1, input logic [2:0] fl,
         input logic exp_end);
      for (int i = 0; i < n; i++) begin
         rx_byte_valid <= 1'b1;
         rx_byte <= (i == 0) ? b0 : (i == 1) ? b1 : 8'(i);
         @(posedge hclk);
      end
      rx_byte_valid <= 1'b0;
      {rx_bit_misalign, rx_check_ok, rx_is_bom} <= fl;
      rx_frame_end <= 1'b1;
      @(posedge hclk);
      rx_frame_end <= 1'b0;
      #1;
      chk("frame end notice", {31'h0, rx_message_end}, {31'h0, exp_end});
      @(posedge hclk);
   endtask
   // A reported frame: status, counts, then the queue is drained; below 32 bytes its last byte is status.
   task automatic rx_case(input int n, input byte_t b0, input byte_t b1, input logic [2:0] fl,
         input byte_t exp, input byte_t m);
      logic [11:0] len;
      logic [4:0] fill;
      len = 12'(n);
      fill = (n < 32) ? 5'(n + 1) : 5'd0;
      frame(n, b0, b1, fl, 1'b1);
      rdc("frame status", A_FST, {24'h0, exp & m}, {24'h0, m});
      rdc("count high", A_CNTH, {28'h0, len[11:8]});
      rdc("count low", A_CNTL, {24'h0, len[7:5], fill});
      repeat (n < 32 ? n + 1 : 33) bus(1'b0, A_RXQ, 32'h0);
      if (n < 32) chk("queued status", rd & {24'h0, m}, {24'h0, exp & m});
   endtask
   // ------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge hclk);
      err_count++;
      stop_test();
   end
   initial begin
      static logic [7:0] ro [5] = '{8'h64, 8'h68, 8'h6c, 8'h70, 8'h80};
      static logic [31:0] cfg [3] = '{32'h0b, 32'h02, 32'h0a};
      static int ninv [3] = '{3, 3, 2};
      {hsel, hwrite, tx_host_write, tx_half_moved, esf_format, auto_switch_en} = '0;
      {bom_active, rx_byte_valid, rx_frame_end, rx_bit_misalign, rx_check_ok} = '0;
      {haddr, rx_byte, htrans, hwdata, rx_is_bom, hresetn} = '0;
      hsize = 3'b010;
      err_count = 0;
      comparisons = 0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      hsel <= 1'b1;
      foreach (ro[i]) begin
         bus(1'b1, ro[i], 32'hff);
         rdc("read only", ro[i], i == 0 ? 32'h40 : 32'h0);
      end
      tx_push(32);
      rdc("status", A_STAT, 32'h00);
      tx_push(1);
      rdc("status", A_STAT, 32'h80);
      tx_half_moved <= 1'b1;
      @(posedge hclk);
      tx_half_moved <= 1'b0;
      rdc("status", A_STAT, 32'h40);
      tx_push(33);
      bus(1'b1, A_CMD, 32'h1);
      rdc("status", A_STAT, 32'h44);
      bus(1'b1, A_CMD, 32'h2);
      rdc("status", A_STAT, 32'h44);
      repeat (100) @(posedge hclk);
      rdc("status", A_STAT, 32'h40);
      bus(1'b1, A_CMD, 32'h2);
      repeat (100) @(posedge hclk);
      rdc("status", A_STAT, 32'h60);
      {esf_format, auto_switch_en, bom_active} <= 3'b111;
      @(posedge hclk);
      rdc("status", A_STAT, 32'h61);
      bom_active <= 1'b0;
      @(posedge hclk);
      rdc("status", A_STAT, 32'h60);
      bus(1'b1, 8'h08, 32'h10);
      bus(1'b1, 8'h0c, 32'h22);
      bus(1'b1, 8'h10, 32'h33);
      bus(1'b1, 8'h14, 32'h44);
      bus(1'b1, A_CFG, 32'h03);
      rx_case(6, 8'h10, 8'h33, 3'b010, 8'hab, 8'hff);
      rx_case(6, 8'h12, 8'h44, 3'b000, 8'h8e, 8'hff);
      rx_case(6, 8'h22, 8'h33, 3'b010, 8'ha3, 8'hff);
      rx_case(6, 8'hfe, 8'h33, 3'b010, 8'ha7, 8'hff);
      rx_case(6, 8'hfc, 8'h33, 3'b010, 8'ha7, 8'hff);
      rx_case(6, 8'h10, 8'h33, 3'b110, 8'h2b, 8'hff);
      rx_case(6, 8'h10, 8'h33, 3'b011, 8'h00, 8'h02);
      rx_case(4, 8'h10, 8'h33, 3'b010, 8'h2b, 8'hff);
      rx_case(33, 8'h10, 8'h33, 3'b010, 8'heb, 8'hff);
      frame(3, 8'h10, 8'h33, 3'b010, 1'b0);
      rdc("queue fill", A_CNTL, 32'h0, 32'h1f);
      foreach (cfg[i]) begin
         bus(1'b1, A_CFG, cfg[i]);
         rx_case(ninv[i], 8'h10, 8'h33, 3'b010, 8'h00, 8'h80);
         frame(ninv[i] - 1, 8'h10, 8'h33, 3'b010, 1'b0);
      end
      bus(1'b1, A_CFG, 32'h10);
      rx_case(3, 8'h10, 8'h33, 3'b010, 8'h04, 8'h1c);
      rx_case(5, 8'h10, 8'h33, 3'b010, 8'h08, 8'h1c);
      rx_case(279, 8'h10, 8'h33, 3'b010, 8'h0c, 8'h1c);
      rx_case(280, 8'h10, 8'h33, 3'b010, 8'h1c, 8'h1c);
      stop_test();
   end
endmodule
